//--- event_capture.sv
/*
 * Event capture front end of a multi-channel transfer controller.
 * Latches one fixed event per channel, gates it by the enable bits and
 * hands the best pending channel to the transfer engine with its priority.
 * Assumes a single clock, AXI4-Lite software access, same-clock events.
 */
`timescale 1ns/1ns
module event_capture
	import evcap_pkg::*;
#(
	parameter int N = NUM_CHAN
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [N-1:0] eventIn,
	output xfer_req_t xferReq,
	output logic xferValid,
	input wire logic xferReady,
	output logic irq,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	logic [N-1:0] latch_q, latch_d, enable_q;
	logic [PRIO_W-1:0] prio_q [N];
	logic [N*PRIO_W-1:0] prioFlat;
	logic [INT_W-1:0] status_q, mask_q;
	logic [ADDR_W-1:0] awAddr_q;
	logic [31:0] wData_q;
	logic [3:0] wStrb_q;
	logic wrDo;
	logic [N-1:0] evPulse, swSet, swClr, issueClr;
	logic [INT_W-1:0] intEv, intClr;
	logic pickFound;
	logic [CHAN_W-1:0] pickChan;
	logic [PRIO_W-1:0] pickPrio;
	logic issue;

	// Merge byte lanes of a write into an old word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = data[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// True when the address selects the same 32-bit word as the given offset
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
		return a[ADDR_W-1:2] == ofs[ADDR_W-1:2];
	endfunction

	// One edge detector per channel input; bit i always feeds channel i
	event_edge #(.N(N)) u_edge (
		.clk(clk),
		.rst(rst),
		.eventIn(eventIn),
		.eventPulse(evPulse)
	);

	// Write address and data channels taken independently
	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_awready <= 1'b1;
			awAddr_q <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			s_axi_awready <= 1'b0;
			awAddr_q <= s_axi_awaddr;
		end else if (wrDo) begin
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_wready <= 1'b1;
			wData_q <= '0;
			wStrb_q <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			s_axi_wready <= 1'b0;
			wData_q <= s_axi_wdata;
			wStrb_q <= s_axi_wstrb;
		end else if (wrDo) begin
			s_axi_wready <= 1'b1;
		end
	end

	// Write commits once both halves are held and no response is pending
	assign wrDo = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wrDo) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (awAddr_q <= OFS_INT_MASK ||
				(awAddr_q >= OFS_PARAM_BASE && awAddr_q <= OFS_PARAM_LAST)) ?
				RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Software set and write-one-to-clear masks for the latch
	always_comb begin
		swSet = '0;
		swClr = '0;
		intClr = '0;
		if (wrDo) begin
			if (hit(awAddr_q, OFS_SET_LOW)) swSet[31:0] = merge('0, wData_q, wStrb_q);
			if (hit(awAddr_q, OFS_SET_HIGH)) swSet[63:32] = merge('0, wData_q, wStrb_q);
			if (hit(awAddr_q, OFS_LATCH_LOW)) swClr[31:0] = merge('0, wData_q, wStrb_q);
			if (hit(awAddr_q, OFS_LATCH_HIGH)) swClr[63:32] = merge('0, wData_q, wStrb_q);
			if (hit(awAddr_q, OFS_INT_STATUS)) intClr = wData_q[INT_W-1:0];
		end
	end

	// Enable bits and interrupt mask
	always_ff @(posedge clk) begin
		if (rst) begin
			enable_q <= RST_ENABLE;
			mask_q <= RST_INT;
		end else if (wrDo) begin
			if (hit(awAddr_q, OFS_ENABLE_LOW)) enable_q[31:0] <= merge(enable_q[31:0], wData_q, wStrb_q);
			if (hit(awAddr_q, OFS_ENABLE_HIGH)) enable_q[63:32] <= merge(enable_q[63:32], wData_q, wStrb_q);
			if (hit(awAddr_q, OFS_INT_MASK)) mask_q <= wData_q[INT_W-1:0];
		end
	end

	// Per-channel priority held in the parameter memory
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < N; i++) begin
				prio_q[i] <= RST_PRIO;
			end
		end else if (wrDo && wStrb_q[0] && awAddr_q >= OFS_PARAM_BASE && awAddr_q <= OFS_PARAM_LAST) begin
			prio_q[awAddr_q[7:2]] <= wData_q[PRIO_LSB +: PRIO_W];
		end
	end

	// Only channels both latched and enabled compete for service
	always_comb begin
		for (int i = 0; i < N; i++) begin
			prioFlat[i*PRIO_W +: PRIO_W] = prio_q[i];
		end
	end

	prio_pick #(.N(N)) u_pick (
		.ready(latch_q & enable_q),
		.prioFlat(prioFlat),
		.found(pickFound),
		.chan(pickChan),
		.prio(pickPrio)
	);

	assign issue = pickFound && (!xferValid || xferReady);
	assign issueClr = issue ? (N'(1) << pickChan) : '0;

	// Latch sets regardless of enable; a set in the clearing cycle wins
	assign latch_d = (latch_q & ~swClr & ~issueClr) | evPulse | swSet;

	always_ff @(posedge clk) begin
		if (rst) begin
			latch_q <= RST_LATCH;
		end else begin
			latch_q <= latch_d;
		end
	end

	// Request to the transfer engine, held until taken
	always_ff @(posedge clk) begin
		if (rst) begin
			xferValid <= 1'b0;
			xferReq <= '0;
		end else if (issue) begin
			xferValid <= 1'b1;
			xferReq.chan <= pickChan;
			xferReq.prio <= pickPrio;
		end else if (xferReady) begin
			xferValid <= 1'b0;
		end
	end

	// Interrupt status: issue and overrun, sticky, write one to clear
	assign intEv[INT_ISSUE] = xferValid && xferReady;
	assign intEv[INT_OVERRUN] = |(evPulse & latch_q);

	always_ff @(posedge clk) begin
		if (rst) begin
			status_q <= RST_INT;
			irq <= 1'b0;
		end else begin
			status_q <= (status_q & ~intClr) | intEv;
			irq <= |(status_q & mask_q);
		end
	end

	// Read channel: one word returned the cycle after the address
	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			s_axi_rdata <= '0;
			if (s_axi_araddr >= OFS_PARAM_BASE && s_axi_araddr <= OFS_PARAM_LAST) begin
				s_axi_rdata[PRIO_LSB +: PRIO_W] <= prio_q[s_axi_araddr[7:2]];
			end else begin
				unique case (s_axi_araddr)
					OFS_LATCH_LOW: s_axi_rdata <= latch_q[31:0];
					OFS_LATCH_HIGH: s_axi_rdata <= latch_q[63:32];
					OFS_ENABLE_LOW: s_axi_rdata <= enable_q[31:0];
					OFS_ENABLE_HIGH: s_axi_rdata <= enable_q[63:32];
					OFS_SET_LOW, OFS_SET_HIGH: s_axi_rdata <= '0;
					OFS_INT_STATUS: s_axi_rdata[INT_W-1:0] <= status_q;
					OFS_INT_MASK: s_axi_rdata[INT_W-1:0] <= mask_q;
					default: s_axi_rresp <= RESP_SLVERR;
				endcase
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// Checks beside the logic
	sequence s_event;
		evPulse != '0;
	endsequence

	sequence s_newReq;
		(!xferValid || xferReady) ##1 (xferValid && $changed(xferReq) || $rose(xferValid));
	endsequence

	property p_latchOnEvent;
		@(posedge clk) disable iff (rst)
		s_event |=> ((latch_q & $past(evPulse)) == $past(evPulse));
	endproperty
	a_latchOnEvent: assert property (p_latchOnEvent) else $error("event not latched");

	property p_pendingHeld;
		@(posedge clk) disable iff (rst)
		1'b1 |=> (($past(latch_q & ~enable_q & ~swClr) & ~latch_q) == '0);
	endproperty
	a_pendingHeld: assert property (p_pendingHeld) else $error("disabled event lost");

	property p_issueFromPending;
		@(posedge clk) disable iff (rst)
		issue |-> (latch_q[pickChan] && enable_q[pickChan]) ##1
			(xferValid && xferReq.chan == $past(pickChan));
	endproperty
	a_issueFromPending: assert property (p_issueFromPending) else $error("bad issue");

	property p_prioFromMemory;
		@(posedge clk) disable iff (rst)
		issue |=> xferReq.prio == $past(prio_q[pickChan]);
	endproperty
	a_prioFromMemory: assert property (p_prioFromMemory) else $error("wrong priority");

	property p_reqHold;
		@(posedge clk) disable iff (rst)
		xferValid && !xferReady |=> xferValid && $stable(xferReq);
	endproperty
	a_reqHold: assert property (p_reqHold) else $error("request dropped");

	property p_enableStarts;
		@(posedge clk) disable iff (rst)
		(latch_q != '0) && ((latch_q & enable_q) != '0) && !xferValid |-> s_newReq;
	endproperty
	a_enableStarts: assert property (p_enableStarts) else $error("pending not started");

	property p_irqLevel;
		@(posedge clk) disable iff (rst)
		1'b1 |=> irq == |($past(status_q) & $past(mask_q));
	endproperty
	a_irqLevel: assert property (p_irqLevel) else $error("irq mismatch");
endmodule

//--- evcap_pkg.sv
/*
 * Shared constants and types for the channel event capture block.
 * Assumes a 32-bit AXI4-Lite register bus and 64 fixed event inputs.
 */
package evcap_pkg;
	localparam int NUM_CHAN = 64;
	localparam int CHAN_W = 6;
	localparam int PRIO_W = 3;
	localparam int ADDR_W = 12;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_LATCH_LOW = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_LATCH_HIGH = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_ENABLE_LOW = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_ENABLE_HIGH = 12'h00C;
	localparam logic [ADDR_W-1:0] OFS_SET_LOW = 12'h010;
	localparam logic [ADDR_W-1:0] OFS_SET_HIGH = 12'h014;
	localparam logic [ADDR_W-1:0] OFS_INT_STATUS = 12'h018;
	localparam logic [ADDR_W-1:0] OFS_INT_MASK = 12'h01C;
	localparam logic [ADDR_W-1:0] OFS_PARAM_BASE = 12'h100;
	localparam logic [ADDR_W-1:0] OFS_PARAM_LAST = 12'h1FC;

	// Parameter word field: priority in the low bits
	localparam int PRIO_LSB = 0;

	// Interrupt status bit positions
	localparam int INT_ISSUE = 0;
	localparam int INT_OVERRUN = 1;
	localparam int INT_W = 2;

	// Reset values
	localparam logic [NUM_CHAN-1:0] RST_LATCH = 64'h0000_0000_0000_0000;
	localparam logic [NUM_CHAN-1:0] RST_ENABLE = 64'h0000_0000_0000_0000;
	localparam logic [PRIO_W-1:0] RST_PRIO = 3'h0;
	localparam logic [INT_W-1:0] RST_INT = 2'h0;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Request handed to the transfer engine
	typedef struct packed {
		logic [CHAN_W-1:0] chan;
		logic [PRIO_W-1:0] prio;
	} xfer_req_t;
endpackage

//--- event_edge.sv
/*
 * Turns each event input into a one-cycle pulse on its rising edge.
 * Assumes the inputs come from peripheral logic on the same clock.
 */
`timescale 1ns/1ns
module event_edge
	import evcap_pkg::*;
#(
	parameter int N = NUM_CHAN
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [N-1:0] eventIn,
	output logic [N-1:0] eventPulse
);
	logic [N-1:0] prev_q;

	// Remember the previous level of every input
	always_ff @(posedge clk) begin
		if (rst) begin
			prev_q <= '0;
		end else begin
			prev_q <= eventIn;
		end
	end

	// Rising edge marks one event
	assign eventPulse = eventIn & ~prev_q;
endmodule

//--- prio_pick.sv
/*
 * Picks the ready channel with the best priority; lowest value wins,
 * ties go to the lowest channel number. Purely combinational.
 */
`timescale 1ns/1ns
module prio_pick
	import evcap_pkg::*;
#(
	parameter int N = NUM_CHAN
) (
	input wire logic [N-1:0] ready,
	input wire logic [N*PRIO_W-1:0] prioFlat,
	output logic found,
	output logic [CHAN_W-1:0] chan,
	output logic [PRIO_W-1:0] prio
);
	// Scan all channels, keeping the best one seen
	always_comb begin
		found = 1'b0;
		chan = '0;
		prio = '1;
		for (int i = 0; i < N; i++) begin
			if (ready[i] && (!found || prioFlat[i*PRIO_W +: PRIO_W] < prio)) begin
				found = 1'b1;
				chan = CHAN_W'(i);
				prio = prioFlat[i*PRIO_W +: PRIO_W];
			end
		end
	end
endmodule

//--- periph_events.sv
/*
 * Peripheral side model: raises one-cycle synchronization events.
 * Assumes events are made on the controller clock, one bit per channel.
 */
`timescale 1ns/1ns
module periph_events
	import evcap_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [NUM_CHAN-1:0] fire,
	output logic [NUM_CHAN-1:0] eventIn
);
	// Each requested bit is registered onto its own fixed line one cycle later
	always_ff @(posedge clk) begin
		if (rst) begin
			eventIn <= {NUM_CHAN{1'b0}};
		end else begin
			eventIn <= fire;
		end
	end
endmodule

//--- event_capture_tb.sv
/*
 * Self-checking testbench for the event capture block.
 * Assumes the peripheral model and the design package are compiled first.
 */
`timescale 1ns/1ns
module event_capture_tb
	import evcap_pkg::*;
;
	logic clk, rst, xferValid, xferReady, irq;
	logic [NUM_CHAN-1:0] fire, eventIn;
	xfer_req_t xferReq;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, d;
	logic [1:0] bresp, rresp, r, lastB;
	logic [3:0] wstrb;
	int n_mismatch, comparisons, cyc;

	periph_events periph_events_i (.clk(clk), .rst(rst), .fire(fire), .eventIn(eventIn));
	event_capture event_capture_i (.clk(clk), .rst(rst), .eventIn(eventIn), .xferReq(xferReq),
		.xferValid(xferValid), .xferReady(xferReady), .irq(irq),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

	// Clock generation
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			n_mismatch++;
		end
	endtask

	// Write: address and data offered together, each released when taken
	task automatic axw(input logic [ADDR_W-1:0] a, input logic [31:0] v);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		lastB = bresp;
		bready <= 1'b0;
		@(posedge clk);
	endtask

	task automatic axr(input logic [ADDR_W-1:0] a, output logic [31:0] v, output logic [1:0] rs);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		v = rdata;
		rs = rresp;
		rready <= 1'b0;
		@(posedge clk);
	endtask

	task automatic fire_ev(input logic [NUM_CHAN-1:0] m);
		fire <= m;
		@(posedge clk);
		fire <= {NUM_CHAN{1'b0}};
		repeat (3) @(posedge clk);
	endtask

	// Engine side: wait for a request, compare it, accept it for one edge
	task automatic wait_req(input logic [CHAN_W-1:0] c, input logic [PRIO_W-1:0] p);
		do @(posedge clk); while (xferValid !== 1'b1);
		chk({26'h0, xferReq.chan}, {26'h0, c});
		chk({29'h0, xferReq.prio}, {29'h0, p});
		xferReady <= 1'b1;
		@(posedge clk);
		xferReady <= 1'b0;
	endtask

	// Main sequence
	initial begin
		rst = 1'b1;
		fire = '0;
		xferReady = 1'b0;
		{awaddr, araddr, wdata} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		wstrb = 4'hF;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		axr(OFS_LATCH_LOW, d, r);
		chk(d, 32'h0000_0000);
		axr(OFS_ENABLE_HIGH, d, r);
		chk(d, 32'h0000_0000);
		// Disabled channel 7 latches twice, then software clears it
		fire_ev(64'h0000_0000_0000_0080);
		fire_ev(64'h0000_0000_0000_0080);
		axr(OFS_LATCH_LOW, d, r);
		chk(d, 32'h0000_0080);
		axr(OFS_INT_STATUS, d, r);
		chk(d, 32'h0000_0002);
		axw(OFS_INT_STATUS, 32'h0000_0002);
		axw(OFS_LATCH_LOW, 32'h0000_0080);
		axw(OFS_ENABLE_LOW, 32'h0000_0080);
		repeat (6) @(posedge clk);
		chk({31'h0, xferValid}, 32'h0000_0000);
		// Enabled channel 5 issues with default priority
		axw(OFS_ENABLE_LOW, 32'h0000_0020);
		fire_ev(64'h0000_0000_0000_0020);
		wait_req(6'h05, 3'h0);
		repeat (3) @(posedge clk);
		chk({31'h0, irq}, 32'h0000_0000);
		axr(OFS_INT_STATUS, d, r);
		chk(d, 32'h0000_0001);
		axw(OFS_INT_MASK, 32'h0000_0001);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0000_0001);
		axw(OFS_INT_STATUS, 32'h0000_0001);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0000_0000);
		// Software set of channel 5 through the low byte lane only
		wstrb <= 4'h1;
		axw(OFS_SET_LOW, 32'hFFFF_FF20);
		wstrb <= 4'hF;
		wait_req(6'h05, 3'h0);
		axr(OFS_LATCH_LOW, d, r);
		chk(d, 32'h0000_0000);
		axr(OFS_SET_LOW, d, r);
		chk(d, 32'h0000_0000);
		// High channels 33 and 40 pend while disabled, then issue by priority
		axw(OFS_PARAM_BASE + 12'h084, 32'h0000_0001);
		axw(OFS_PARAM_BASE + 12'h0A0, 32'h0000_0002);
		axr(OFS_PARAM_BASE + 12'h0A0, d, r);
		chk(d, 32'h0000_0002);
		chk({30'h0, r}, {30'h0, RESP_OKAY});
		chk({30'h0, lastB}, {30'h0, RESP_OKAY});
		fire_ev(64'h0000_0102_0000_0000);
		axr(OFS_LATCH_HIGH, d, r);
		chk(d, 32'h0000_0102);
		axw(OFS_ENABLE_HIGH, 32'h0000_0102);
		wait_req(6'h21, 3'h1);
		wait_req(6'h28, 3'h2);
		// Disabled channel 63 set by software stays pending until cleared
		axw(OFS_SET_HIGH, 32'h8000_0000);
		axr(OFS_LATCH_HIGH, d, r);
		chk(d, 32'h8000_0000);
		axw(OFS_LATCH_HIGH, 32'h8000_0000);
		axr(OFS_LATCH_HIGH, d, r);
		chk(d, 32'h0000_0000);
		chk({31'h0, xferValid}, 32'h0000_0000);
		// Unmapped address is refused
		axw(12'h020, 32'hFFFF_FFFF);
		chk({30'h0, lastB}, {30'h0, RESP_SLVERR});
		axr(12'h020, d, r);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		chk(d, 32'h0000_0000);
		tally_and_finish();
	end
endmodule
